//--- logic/ifr_pkg.sv
// How it works
// - Functions come from eight direct terminals and from remote inputs.
// - Each terminal owns a selection code choosing its function.
// - Reset codes are 3,4,48,49,50,16,18,24 for terminals 0 to 7.
// - Code 0 leaves the terminal unused.
// - Codes 1 and 2 request continuous positive and negative motion.
// - Codes 3, 4, 5 request home, positioning, sequential positioning.
// - Codes 6 and 7 request jog positive and jog negative.
// - Codes 8 to 13 drive the six direct positioning requests in order.
// - Code 16 selects free-run.
// - Code 17 selects excitation control.
// - Code 18 selects stop.
// - Code 24 selects fault clear.
// - Code 25 selects position preset, 26 absolute error clear.
// - Code 27 selects setting-tool lock.
// - Codes 32 to 47 drive sixteen general signals in order.
// - Codes 48 to 53 drive data select bits, lowest first.
// - One function on several terminals is the OR of them.
// - Fault clear and error clear fire on the ON to OFF edge.
// - Position preset fires on the OFF to ON edge.
// - Unassigned excitation control and tool lock read constantly ON.
// - Those two, assigned on both sources, need both ON.
// - Per-terminal polarity; 0 normally open, 1 inverted; reset 0.
package ifr_pkg;
   localparam int N_TERM    = 8;
   localparam int N_FUNC    = 64;
   localparam int CODE_W    = 6;
   localparam logic [5:0] C_NONE    = 6'h00;
   localparam logic [5:0] C_CPOS    = 6'h01;
   localparam logic [5:0] C_CNEG    = 6'h02;
   localparam logic [5:0] C_HOME    = 6'h03;
   localparam logic [5:0] C_START   = 6'h04;
   localparam logic [5:0] C_SEQPOS  = 6'h05;
   localparam logic [5:0] C_JOGP    = 6'h06;
   localparam logic [5:0] C_JOGN    = 6'h07;
   localparam logic [5:0] C_DPOS0   = 6'h08;
   localparam logic [5:0] C_DPOS5   = 6'h0d;
   localparam logic [5:0] C_FREE    = 6'h10;
   localparam logic [5:0] C_EXC     = 6'h11;
   localparam logic [5:0] C_STOP    = 6'h12;
   localparam logic [5:0] C_FCLR    = 6'h18;
   localparam logic [5:0] C_PRESET  = 6'h19;
   localparam logic [5:0] C_ECLR    = 6'h1a;
   localparam logic [5:0] C_LOCK    = 6'h1b;
   localparam logic [5:0] C_GEN0    = 6'h20;
   localparam logic [5:0] C_GEN15   = 6'h2f;
   localparam logic [5:0] C_SEL0    = 6'h30;
   localparam logic [5:0] C_SEL5    = 6'h35;
   // Selection code reset values, terminal 0 in the low slot
   localparam logic [47:0] CODE_RST =
      {6'h18, 6'h12, 6'h10, 6'h32, 6'h31, 6'h30, 6'h04, 6'h03};
   localparam logic [7:0]  POL_RST  = 8'h00;

   typedef struct packed {
      logic       cont_pos;
      logic       cont_neg;
      logic       home;
      logic       position;
      logic       seq_position;
      logic       jog_pos;
      logic       jog_neg;
      logic [5:0] direct_pos;
      logic       free_run;
      logic       excitation;
      logic       stop;
      logic       fault_clear;
      logic       position_preset;
      logic       abs_err_clear;
      logic       tool_lock;
      logic [15:0] general;
      logic [5:0] op_data_select;
   } ifr_func_t;

   typedef struct packed {
      logic [47:0] code;
      logic [7:0]  pol;
   } ifr_cfg_t;
endpackage : ifr_pkg

//--- logic/ifr_decode.sv
`timescale 1ns/1ps
`default_nettype none
module ifr_decode (
   input  wire logic [47:0]  codes,     // Eight 6-bit selection codes
   input  wire logic [7:0]   levels,    // Polarity-corrected terminal levels
   output logic      [63:0]  func_or,   // OR of terminals per code
   output logic      [63:0]  func_used  // Code assigned to some terminal
);
   always_comb begin
      func_or   = '0;
      func_used = '0;
      for (int t = 0; t < ifr_pkg::N_TERM; t++) begin
         func_used[codes[t*6 +: 6]] = 1'b1;
         if (levels[t]) begin
            func_or[codes[t*6 +: 6]] = 1'b1;
         end
      end
      func_or[0]   = 1'b0;
      func_used[0] = 1'b0;
   end
endmodule : ifr_decode
`default_nettype wire

//--- logic/ifr_router.sv
`timescale 1ns/1ps
`default_nettype none
module ifr_router (
   input  wire logic             sys_clk,      // 250 MHz clock
   input  wire logic             rst,          // Synchronous reset, high
   input  wire logic [7:0]       input_connector, // Terminal pins 0..7
   input  wire logic             cfg_we,       // Write one selection code
   input  wire logic [2:0]       cfg_term,     // Terminal being written
   input  wire logic [5:0]       cfg_code,     // New selection code
   input  wire logic             cfg_pol,      // New polarity, 1 inverts
   input  wire ifr_pkg::ifr_func_t remote_in,  // Remote functions
   input  wire logic             remote_exc_used,  // Remote assigns exc.
   input  wire logic             remote_lock_used, // Remote assigns lock
   output ifr_pkg::ifr_func_t    func_out,     // Combined functions
   output logic [47:0]           code_rd,      // Current selection codes
   output logic [7:0]            pol_rd        // Current polarities
);
   typedef struct packed {
      logic [7:0]         s1;
      logic [7:0]         s2;
      ifr_pkg::ifr_cfg_t  cfg;
      logic               eclr_prev;
      logic               fclr_prev;
      logic               pre_prev;
      ifr_pkg::ifr_func_t out;
   } ifr_state_t;

   ifr_state_t st_q;
   ifr_state_t st_d;
   logic [63:0] f_or;
   logic [63:0] f_used;

   ifr_decode u_dec (
      .codes     (st_q.cfg.code),
      .levels    (st_q.s2 ^ st_q.cfg.pol),
      .func_or   (f_or),
      .func_used (f_used)
   );

   // Codes outside the table simply land on unread slots
   function automatic logic pick(input logic [63:0] v,
                                 input logic [5:0] c);
      return v[c];
   endfunction : pick

   always_comb begin
      logic fclr_lvl;
      logic eclr_lvl;
      logic pre_lvl;
      logic exc_d;
      logic exc_r;
      logic lk_d;
      logic lk_r;
      fclr_lvl = 1'b0;
      eclr_lvl = 1'b0;
      pre_lvl  = 1'b0;
      exc_d    = 1'b0;
      exc_r    = 1'b0;
      lk_d     = 1'b0;
      lk_r     = 1'b0;
      st_d     = st_q;
      st_d.s1  = input_connector;
      st_d.s2  = st_q.s1;
      if (cfg_we) begin
         st_d.cfg.code[cfg_term*6 +: 6] = cfg_code;
         st_d.cfg.pol[cfg_term]         = cfg_pol;
      end
      // Direct OR remote for level functions
      st_d.out.cont_pos = pick(f_or, ifr_pkg::C_CPOS)
                          | remote_in.cont_pos;
      st_d.out.cont_neg = pick(f_or, ifr_pkg::C_CNEG)
                          | remote_in.cont_neg;
      st_d.out.home = pick(f_or, ifr_pkg::C_HOME)
                      | remote_in.home;
      st_d.out.position = pick(f_or, ifr_pkg::C_START)
                          | remote_in.position;
      st_d.out.seq_position = pick(f_or, ifr_pkg::C_SEQPOS)
                              | remote_in.seq_position;
      st_d.out.jog_pos = pick(f_or, ifr_pkg::C_JOGP)
                         | remote_in.jog_pos;
      st_d.out.jog_neg = pick(f_or, ifr_pkg::C_JOGN)
                         | remote_in.jog_neg;
      st_d.out.direct_pos = f_or[13:8] | remote_in.direct_pos;
      st_d.out.free_run = pick(f_or, ifr_pkg::C_FREE)
                          | remote_in.free_run;
      st_d.out.stop = pick(f_or, ifr_pkg::C_STOP)
                      | remote_in.stop;
      st_d.out.general = f_or[47:32] | remote_in.general;
      st_d.out.op_data_select = f_or[53:48]
                                | remote_in.op_data_select;
      // Excitation and tool lock: ON when unassigned, AND across sources
      exc_d = pick(f_used, ifr_pkg::C_EXC)
              ? pick(f_or, ifr_pkg::C_EXC) : 1'b1;
      exc_r = remote_exc_used ? remote_in.excitation : 1'b1;
      st_d.out.excitation = exc_d & exc_r;
      lk_d = pick(f_used, ifr_pkg::C_LOCK)
             ? pick(f_or, ifr_pkg::C_LOCK) : 1'b1;
      lk_r = remote_lock_used ? remote_in.tool_lock : 1'b1;
      st_d.out.tool_lock = lk_d & lk_r;
      // Edge-executed functions give one-cycle pulses
      fclr_lvl = pick(f_or, ifr_pkg::C_FCLR) | remote_in.fault_clear;
      eclr_lvl = pick(f_or, ifr_pkg::C_ECLR) | remote_in.abs_err_clear;
      pre_lvl  = pick(f_or, ifr_pkg::C_PRESET)
                 | remote_in.position_preset;
      st_d.fclr_prev = fclr_lvl;
      st_d.eclr_prev = eclr_lvl;
      st_d.pre_prev  = pre_lvl;
      st_d.out.fault_clear = st_q.fclr_prev & ~fclr_lvl;
      st_d.out.abs_err_clear = st_q.eclr_prev & ~eclr_lvl;
      st_d.out.position_preset = ~st_q.pre_prev & pre_lvl;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_q          <= '0;
         st_q.cfg.code <= ifr_pkg::CODE_RST;
         st_q.cfg.pol  <= ifr_pkg::POL_RST;
      end else begin
         st_q <= st_d;
      end
   end

   assign func_out = st_q.out;
   assign code_rd  = st_q.cfg.code;
   assign pol_rd   = st_q.cfg.pol;
endmodule : ifr_router
`default_nettype wire

//--- tb/ifr_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module ifr_ctrl_model (
   input  wire logic       sys_clk, // Clock
   input  wire logic [7:0] want,    // Requested levels
   output logic      [7:0] pins     // Terminal levels
);
   // Output stage answers one cycle after a request
   always_ff @(posedge sys_clk) pins <= want;
endmodule : ifr_ctrl_model
`default_nettype wire

//--- tb/ifr_router_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ifr_chk (
   input wire logic               sys_clk, // Clock
   input wire logic               rst, // Reset
   input wire logic               cfg_we, // Write
   input wire logic [2:0]         cfg_term, // Terminal
   input wire logic [5:0]         cfg_code, // Code
   input wire ifr_pkg::ifr_func_t remote_in, // Remote
   input wire logic               remote_exc_used, // Remote exc
   input wire logic               remote_lock_used, // Remote lock
   input wire ifr_pkg::ifr_func_t func_out, // Functions
   input wire logic [47:0]        code_rd, // Codes
   input wire logic [7:0]         pol_rd // Polarities
);
   ifr_pkg::ifr_func_t f;
   ifr_pkg::ifr_func_t r;
   logic               exc_asg;
   assign f = func_out;
   assign r = remote_in;
   always_comb begin
      exc_asg = 1'b0;
      for (int i = 0; i < 8; i++) exc_asg |= (code_rd[6*i +: 6] == 6'h11);
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   property p_rst;
      disable iff (1'b0)
         rst |=> code_rd == 48'h612432c70103 && pol_rd == 8'h00;
   endproperty
   property p_wr;
      cfg_we |=> code_rd[$past(cfg_term)*6 +: 6] == $past(cfg_code);
   endproperty
   property p_fclr; f.fault_clear |=> !f.fault_clear; endproperty
   property p_pre; f.position_preset |=> !f.position_preset; endproperty
   property p_gen; 1'b1 |=> &(f.general | ~$past(r.general)); endproperty
   property p_cpos; r.cont_pos |=> f.cont_pos; endproperty
   property p_lock;
      remote_lock_used && !r.tool_lock |=> !f.tool_lock;
   endproperty
   property p_exc; !remote_exc_used && !exc_asg |=> f.excitation; endproperty
   a_rst: assert property (p_rst) else $error("reset codes");
   a_wr: assert property (p_wr) else $error("code write");
   a_fclr: assert property (p_fclr) else $error("clear pulse");
   a_pre: assert property (p_pre) else $error("preset pulse");
   a_gen: assert property (p_gen) else $error("general or");
   a_cpos: assert property (p_cpos) else $error("remote run");
   a_lock: assert property (p_lock) else $error("lock and");
   a_exc: assert property (p_exc) else $error("exc default");
   c_fclr: cover property (f.fault_clear);
   c_pre: cover property (f.position_preset);
   c_lock: cover property (remote_lock_used && f.general != 16'h0000);
endmodule : ifr_chk
bind ifr_router ifr_chk u_chk (.sys_clk, .rst, .cfg_we, .cfg_term,
   .cfg_code, .remote_in, .remote_exc_used, .remote_lock_used, .func_out,
   .code_rd, .pol_rd);
`default_nettype wire

//--- tb/tb_input_function_router.sv
`timescale 1ns/1ps
`default_nettype none
module tb_input_function_router;
   logic               sys_clk = 1'b0;
   logic               rst = 1'b1;
   logic               we = 1'b0, pol = 1'b0, lock_u = 1'b0, exc_u = 1'b0;
   logic [2:0]         term = 3'h0;
   logic [5:0]         code = 6'h00;
   logic [7:0]         want = 8'h00, pins, prd;
   logic [47:0]        crd;
   ifr_pkg::ifr_func_t rem = '0, fo, e;
   int                 n_errors = 0, num_checks = 0;
   always #2 sys_clk = ~sys_clk;
   ifr_ctrl_model u_ctl (.sys_clk(sys_clk), .want(want), .pins(pins));
   ifr_router uut (.sys_clk(sys_clk), .rst(rst), .input_connector(pins),
      .cfg_we(we), .cfg_term(term), .cfg_code(code), .cfg_pol(pol),
      .remote_in(rem), .remote_exc_used(exc_u), .remote_lock_used(lock_u),
      .func_out(fo), .code_rd(crd), .pol_rd(prd));
   task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic fchk(input ifr_pkg::ifr_func_t x);
      chk({6'h00, fo}, {6'h00, x});
   endtask : fchk
   task automatic wrap_up;
      if (n_errors == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : wrap_up
   // Expected outputs with terminal 0 on code c; pulses only when asked
   function automatic ifr_pkg::ifr_func_t ex(int c, logic lv, rs, fl);
      logic [41:0] b;
      int          p;
      b = 42'h00008400000;
      p = c < 8 ? 42 - c : c < 14 ? 21 + c : c < 19 ? 44 - c :
          c < 28 ? 49 - c : c < 48 ? c - 26 : c - 48;
      if (c inside {[1:13], [16:18], [24:27], [32:53]})
         b[p] = (c == 24 || c == 26) ? fl : (c == 25 ? rs : lv);
      return ifr_pkg::ifr_func_t'(b);
   endfunction : ex
   task automatic wr(input logic [2:0] t, input logic [5:0] c, input logic p);
      @(posedge sys_clk);
      we <= 1'b1;
      term <= t;
      code <= c;
      pol <= p;
      @(posedge sys_clk);
      we <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask : wr
   task automatic pin(input logic [7:0] v);
      @(posedge sys_clk);
      want <= v;
      repeat (4) @(posedge sys_clk);
      #1;
   endtask : pin
   initial begin
      #40000;
      n_errors++;
      wrap_up();
   end
   initial begin
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk(crd, 48'h612432c70103);
      fchk(ex(0, 1'b0, 1'b0, 1'b0));
      pin(8'h01);
      fchk(ex(3, 1'b1, 1'b0, 1'b0));
      for (int c = 0; c < 64; c++) begin
         wr(3'h0, 6'(c), 1'b0);
         chk({42'h0, crd[5:0]}, 48'(c));
         fchk(ex(c, 1'b0, 1'b0, 1'b0));
         pin(8'h01);
         fchk(ex(c, 1'b1, 1'b1, 1'b0));
         @(posedge sys_clk);
         #1;
         fchk(ex(c, 1'b1, 1'b0, 1'b0));
         pin(8'h00);
         fchk(ex(c, 1'b0, 1'b0, 1'b1));
      end
      wr(3'h3, 6'h01, 1'b1);
      chk({40'h0, prd}, 48'h08);
      @(posedge sys_clk);
      lock_u <= 1'b1;
      rem.general[5] <= 1'b1;
      pin(8'h10);
      e = ex(1, 1'b1, 1'b0, 1'b0);
      e.op_data_select[2] = 1'b1;
      e.general[5] = 1'b1;
      e.tool_lock = 1'b0;
      fchk(e);
      @(posedge sys_clk);
      exc_u <= 1'b1;
      repeat (2) @(posedge sys_clk);
      #1;
      e.excitation = 1'b0;
      fchk(e);
      wrap_up();
   end
endmodule : tb_input_function_router
`default_nettype wire
